// File: core/tldc_consts.vh
`ifndef TLDC_CONSTS_VH
`define TLDC_CONSTS_VH

// register byte offsets
`define TLDC_OFS_SW_A      8'h00
`define TLDC_OFS_SW_B      8'h04
`define TLDC_OFS_EMG_TRQ   8'h08
`define TLDC_OFS_STATUS    8'h0c
`define TLDC_OFS_IRQ_STAT  8'h10
`define TLDC_OFS_IRQ_MASK  8'h14

// function_switch_word_a fields
`define TLDC_A_FWD_IGN     2
`define TLDC_A_REV_IGN     3
`define TLDC_A_SO_COAST    6
`define TLDC_A_SO_DB_HOLD  7
`define TLDC_A_OT_DECEL    8
`define TLDC_A_OT_ZCLAMP   9

// function_switch_word_b fields
`define TLDC_B_REV_MODE    0

// irq status / mask fields
`define TLDC_IRQ_FWD_OT    0
`define TLDC_IRQ_REV_OT    1
`define TLDC_IRQ_STOPPED   2

// reset values
`define TLDC_RST_SW_A      16'h0080
`define TLDC_RST_SW_B      16'h0000
`define TLDC_RST_EMG_TRQ   16'h0000
`define TLDC_RST_IRQ_MASK  3'h0

`endif

// File: core/tldc_ctrl.v
// Functional notes
// - with the direction select bit at 0, counterclockwise seen from the drive end is forward.
// - with the direction select bit at 1, clockwise is forward and the axial sign is inverted, nothing else changes.
// - the encoder connector strap forces reverse direction mode whatever the select bit holds.
// - forward limit low allows forward rotation; high blocks forward but still permits reverse.
// - reverse limit low allows reverse rotation; high blocks reverse but still permits forward.
// - forward limit enable bit at 0 honours the forward limit; at 1 forward rotation is always allowed.
// - reverse limit enable bit at 0 honours the reverse limit; at 1 reverse rotation is always allowed.
// - an honoured limit that is active forces a stop of motion in the prohibited direction.
// - two bits, reset 0, select the overtravel stop method and the after-stop action, used only with limits in use.
// - configuration is split into on/off switch words and numeric constants.
// - stop method 0 stops as at servo-off (brake or coast); 1 decelerates with the emergency stop torque.
// - after a decelerating stop, after-stop bit 0 turns the servo off and 1 holds zero-clamp.
// - in torque control mode an overtravel stop follows servo-off behaviour, ignoring the stop method bit.
//
// Design decisions made here: the address map and the strobed register port.
`include "tldc_consts.vh"

module tldc_ctrl (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // pins from the machine
    input  wire        forward_travel_limit,
    input  wire        reverse_travel_limit,
    input  wire        encoder_connector_strap,
    // motion request from the core logic
    input  wire        run_req,
    input  wire        run_reverse,
    input  wire        torque_mode,
    input  wire        motor_stopped,
    // motion control outputs
    output reg         motor_cw_q,
    output reg         axis_invert_q,
    output reg         run_allow_q,
    output reg         fwd_allowed_q,
    output reg         rev_allowed_q,
    output reg         stop_dyn_brake_q,
    output reg         stop_coast_q,
    output reg         stop_decel_q,
    output reg  [15:0] stop_torque_q,
    output reg         servo_off_q,
    output reg         zero_clamp_q,
    // interrupt
    output wire        irq
);

    // overtravel states, one-hot
    localparam [2:0] ST_RUN  = 3'h1;
    localparam [2:0] ST_STOP = 3'h2;
    localparam [2:0] ST_HELD = 3'h4;

    // three-stage input conditioning: a level is taken once stages two and three agree
    function tldc_filt;
        input [2:0] sh;
        input       cur;
        begin
            tldc_filt = cur;
            if (sh[1] == sh[2]) begin
                tldc_filt = sh[2];
            end
        end
    endfunction

    // register write decode
    function tldc_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            tldc_hit = (a == ofs);
        end
    endfunction

    // switch words and numeric constant kept apart
    reg  [15:0] sw_a_q;
    reg  [15:0] sw_b_q;
    reg  [15:0] emg_trq_q;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_mask_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [2:0]  fwd_sh_q;
    reg  [2:0]  rev_sh_q;
    reg  [2:0]  strap_sh_q;
    reg         fwd_lim_q;
    reg         rev_lim_q;
    reg         strap_q;
    reg         fwd_ot_q;
    reg         rev_ot_q;
    wire        fwd_f;
    wire        rev_f;
    wire        strap_f;
    wire        rev_mode;
    wire        fwd_block;
    wire        rev_block;
    wire        ot_hit;
    wire        ot_decel;
    wire        fwd_ot_rise;
    wire        rev_ot_rise;
    wire        stop_done;
    wire [2:0]  irq_ev;
    wire [2:0]  irq_clr;

    // input synchronisers; only stages two and three are looked at
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fwd_sh_q   <= 3'h0;
            rev_sh_q   <= 3'h0;
            strap_sh_q <= 3'h0;
        end else begin
            fwd_sh_q   <= {fwd_sh_q[1:0], forward_travel_limit};
            rev_sh_q   <= {rev_sh_q[1:0], reverse_travel_limit};
            strap_sh_q <= {strap_sh_q[1:0], encoder_connector_strap};
        end
    end

    assign fwd_f   = tldc_filt(fwd_sh_q, fwd_lim_q);
    assign rev_f   = tldc_filt(rev_sh_q, rev_lim_q);
    assign strap_f = tldc_filt(strap_sh_q, strap_q);

    // filtered levels; limits reset to blocked, but read low from the first clock after reset until the pins pass the synchroniser
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fwd_lim_q <= 1'b1;
            rev_lim_q <= 1'b1;
            strap_q   <= 1'b0;
        end else begin
            fwd_lim_q <= fwd_f;
            rev_lim_q <= rev_f;
            strap_q   <= strap_f;
        end
    end

    // direction mode: strap overrides the switch bit
    assign rev_mode = sw_b_q[`TLDC_B_REV_MODE] | strap_q;

    // honoured limits; high means prohibited, both high blocks both ways
    assign fwd_block = ~sw_a_q[`TLDC_A_FWD_IGN] & fwd_lim_q;
    assign rev_block = ~sw_a_q[`TLDC_A_REV_IGN] & rev_lim_q;

    // request into a prohibited direction
    assign ot_hit = run_req & (run_reverse ? rev_block : fwd_block);

    // decelerating stop only outside torque mode
    assign ot_decel = sw_a_q[`TLDC_A_OT_DECEL] & ~torque_mode;

    // overtravel entry events, one per direction
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fwd_ot_q <= 1'b0;
            rev_ot_q <= 1'b0;
        end else begin
            fwd_ot_q <= run_req & ~run_reverse & fwd_block;
            rev_ot_q <= run_req & run_reverse & rev_block;
        end
    end

    assign fwd_ot_rise = run_req & ~run_reverse & fwd_block & ~fwd_ot_q;
    assign rev_ot_rise = run_req & run_reverse & rev_block & ~rev_ot_q;
    assign stop_done   = state_q[1] & motor_stopped;

    // overtravel sequence: stop, then hold until the request leaves the blocked side
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (ot_hit) begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (motor_stopped) begin
                    state_d = ST_HELD;
                end
            end
            ST_HELD: begin
                if (!ot_hit) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // motion outputs are registered so they never glitch toward the drive stage
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            motor_cw_q       <= 1'b0;
            axis_invert_q    <= 1'b0;
            run_allow_q      <= 1'b0;
            fwd_allowed_q    <= 1'b0;
            rev_allowed_q    <= 1'b0;
            stop_dyn_brake_q <= 1'b0;
            stop_coast_q     <= 1'b0;
            stop_decel_q     <= 1'b0;
            stop_torque_q    <= 16'h0000;
            servo_off_q      <= 1'b0;
            zero_clamp_q     <= 1'b0;
        end else begin
            motor_cw_q       <= run_reverse ^ rev_mode;
            axis_invert_q    <= rev_mode;
            fwd_allowed_q    <= ~fwd_block;
            rev_allowed_q    <= ~rev_block;
            run_allow_q      <= run_req & ~ot_hit & state_d[0];
            stop_decel_q     <= state_d[1] & ot_decel;
            stop_torque_q    <= (state_d[1] & ot_decel) ? emg_trq_q : 16'h0000;
            // servo-off style stop: brake or coast per the servo-off bits
            stop_dyn_brake_q <= ~sw_a_q[`TLDC_A_SO_COAST] & ~ot_decel &
                                (state_d[1] | (state_d[2] & sw_a_q[`TLDC_A_SO_DB_HOLD]));
            stop_coast_q     <= sw_a_q[`TLDC_A_SO_COAST] & ~ot_decel & state_d[1];
            // after-stop action
            zero_clamp_q     <= state_d[2] & ot_decel & sw_a_q[`TLDC_A_OT_ZCLAMP];
            servo_off_q      <= (state_d[1] & ~ot_decel) |
                                (state_d[2] & ~(ot_decel & sw_a_q[`TLDC_A_OT_ZCLAMP]));
        end
    end

    // interrupt events and write-one-to-clear; a new event beats the clear
    assign irq_ev  = {stop_done, rev_ot_rise, fwd_ot_rise};
    assign irq_clr = (reg_wr && tldc_hit(reg_addr, `TLDC_OFS_IRQ_STAT)) ? reg_wdata[2:0] : 3'h0;
    assign irq     = |(irq_stat_q & irq_mask_q);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end

    // register writes; stop bits default 0 so the servo-off stop is the safe default
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sw_a_q     <= `TLDC_RST_SW_A;
            sw_b_q     <= `TLDC_RST_SW_B;
            emg_trq_q  <= `TLDC_RST_EMG_TRQ;
            irq_mask_q <= `TLDC_RST_IRQ_MASK;
        end else if (reg_wr) begin
            if (tldc_hit(reg_addr, `TLDC_OFS_SW_A)) begin
                sw_a_q <= reg_wdata[15:0];
            end
            if (tldc_hit(reg_addr, `TLDC_OFS_SW_B)) begin
                sw_b_q <= reg_wdata[15:0];
            end
            if (tldc_hit(reg_addr, `TLDC_OFS_EMG_TRQ)) begin
                emg_trq_q <= reg_wdata[15:0];
            end
            if (tldc_hit(reg_addr, `TLDC_OFS_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata[2:0];
            end
        end
    end

    // read data stand one cycle after the strobe only; unmapped reads give zero
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TLDC_OFS_SW_A: begin
                    reg_rdata <= {16'h0000, sw_a_q};
                end
                `TLDC_OFS_SW_B: begin
                    reg_rdata <= {16'h0000, sw_b_q};
                end
                `TLDC_OFS_EMG_TRQ: begin
                    reg_rdata <= {16'h0000, emg_trq_q};
                end
                `TLDC_OFS_STATUS: begin
                    reg_rdata <= {23'h000000, state_q, strap_q, rev_mode,
                                  rev_lim_q, fwd_lim_q, rev_block, fwd_block};
                end
                `TLDC_OFS_IRQ_STAT: begin
                    reg_rdata <= {29'h00000000, irq_stat_q};
                end
                `TLDC_OFS_IRQ_MASK: begin
                    reg_rdata <= {29'h00000000, irq_mask_q};
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// File: tb/tldc_ctrl_sva.sv
`include "tldc_consts.vh"

module tldc_ctrl_chk (
    // clock, reset and register port
    input logic        core_clk, rst, reg_wr, reg_rd,
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata, reg_rdata,
    // pins and motion request
    input logic        forward_travel_limit, reverse_travel_limit,
    input logic        encoder_connector_strap, run_req, run_reverse, torque_mode,
    // motion outputs
    input logic        motor_cw_q, axis_invert_q, run_allow_q, fwd_allowed_q,
    input logic        rev_allowed_q, stop_dyn_brake_q, stop_coast_q, stop_decel_q, irq,
    input logic [15:0] stop_torque_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ign_f_q, ign_r_q, rev_sel_q;
    logic [2:0] mask_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // shadow of the switch bits, so the properties know which limits are honoured
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {ign_f_q, ign_r_q, rev_sel_q, mask_q} <= 6'h0;
        end else if (reg_wr) begin
            if (reg_addr == `TLDC_OFS_SW_A) {ign_r_q, ign_f_q} <= reg_wdata[3:2];
            if (reg_addr == `TLDC_OFS_SW_B) rev_sel_q <= reg_wdata[0];
            if (reg_addr == `TLDC_OFS_IRQ_MASK) mask_q <= reg_wdata[2:0];
        end
    end
    // six steady samples cover the three-flop synchroniser plus filter
    sequence s_fwd_hit; (forward_travel_limit && !ign_f_q)[*6]; endsequence
    // ignoring acts at the next update, but a low pin must clear the whole pipeline first
    sequence s_fwd_free; (!forward_travel_limit)[*6] or ign_f_q[*2]; endsequence
    sequence s_rev_hit; (reverse_travel_limit && !ign_r_q)[*6]; endsequence
    sequence s_rev_free; (!reverse_travel_limit)[*6] or ign_r_q[*2]; endsequence
    sequence s_dir_calm;
        ($stable(encoder_connector_strap) && $stable(run_reverse) && $stable(rev_sel_q))[*6];
    endsequence
    a_fwd_block: assert property (s_fwd_hit |-> !fwd_allowed_q)
        else $error("forward limit not blocking");
    a_fwd_free: assert property (s_fwd_free |-> fwd_allowed_q)
        else $error("forward blocked without cause");
    a_rev_block: assert property (s_rev_hit |-> !rev_allowed_q)
        else $error("reverse limit not blocking");
    a_rev_free: assert property (s_rev_free |-> rev_allowed_q)
        else $error("reverse blocked without cause");
    a_dir_map: assert property (s_dir_calm |->
        motor_cw_q == (run_reverse ^ (rev_sel_q | encoder_connector_strap)))
        else $error("rotation sense wrong");
    a_axis_sign: assert property (s_dir_calm |-> axis_invert_q == (rev_sel_q | encoder_connector_strap))
        else $error("axial sign wrong");
    a_run_cause: assert property (run_allow_q |-> $past(run_req))
        else $error("run without request");
    a_both_block: assert property ((!fwd_allowed_q && !rev_allowed_q)[*2] |-> !run_allow_q)
        else $error("run while both sides blocked");
    a_decel_only: assert property (stop_decel_q |-> !stop_dyn_brake_q && !stop_coast_q)
        else $error("two stop styles at once");
    a_torque_mode: assert property (torque_mode[*2] |-> !stop_decel_q)
        else $error("decel stop in torque mode");
    a_torque_idle: assert property (!stop_decel_q |-> stop_torque_q == 16'h0)
        else $error("stop torque outside decel");
    a_irq_mask: assert property (irq |-> mask_q != 3'h0)
        else $error("interrupt with all masked");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind tldc_ctrl tldc_ctrl_chk i_chk (.*);

// File: tb/tldc_limit_sw.sv
module tldc_limit_sw #(
    parameter int LIM = 100
) (
    // clock and reset
    input  logic       core_clk, rst,
    // motion seen at the drive, overrides from the bench
    input  logic       run_allow_q, motor_cw_q, axis_invert_q,
    input  logic [1:0] frc,
    // switch contacts and standstill sense
    output logic       forward_travel_limit, reverse_travel_limit, motor_stopped
);
    timeunit 1ns;
    timeprecision 1ps;
    int         pos_q;
    logic [3:0] idle_q;
    // one step a cycle while running; standstill comes slowly so the stop phase shows
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pos_q  <= 0;
            idle_q <= 4'h0;
        end else begin
            if (run_allow_q) pos_q <= (motor_cw_q ^ axis_invert_q) ? pos_q - 1 : pos_q + 1;
            idle_q <= run_allow_q ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
        end
    end
    // contacts open past each end of travel, or when the bench forces them
    assign forward_travel_limit = frc[0] | (pos_q >= LIM);
    assign reverse_travel_limit = frc[1] | (pos_q <= -LIM);
    assign motor_stopped        = idle_q == 4'hf;
endmodule

// File: tb/travel_limit_direction_ctrl_tb_top.sv
`include "tldc_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end

module travel_limit_direction_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, l = 32'h0652;
    logic        encoder_connector_strap = 1'h0, run_req = 1'h0, run_reverse = 1'h0, torque_mode = 1'h0;
    logic [1:0]  frc = 2'h0;
    logic        forward_travel_limit, reverse_travel_limit, motor_stopped, irq;
    logic        motor_cw_q, axis_invert_q, run_allow_q, fwd_allowed_q, rev_allowed_q;
    logic        stop_dyn_brake_q, stop_coast_q, stop_decel_q, servo_off_q, zero_clamp_q;
    logic [15:0] stop_torque_q;
    logic [15:0] sw_tab [5] = '{16'h0000, 16'h0040, 16'h0100, 16'h0300, 16'h0300};
    logic [4:0]  e;
    int          err_count = 0, samples_checked = 0, i, k;

    tldc_ctrl i_dut (.*);
    tldc_limit_sw i_sw (.*);
    always #5 core_clk = ~core_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // strobes drop with a gap cycle so back-to-back calls never drive twice in one step
    task automatic wr(input [7:0] a, input [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        cyc(1);
        reg_wr <= 1'h0;
        cyc(1);
    endtask
    task automatic rd(input [7:0] a, input [31:0] x);
        reg_addr <= a;
        reg_rd <= 1'h1;
        cyc(1);
        reg_rd <= 1'h0;
        cyc(1);
        `CHK("reg_rdata", x, reg_rdata)
    endtask
    function automatic [31:0] lfsr(input [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // {brake, coast, decel, servo off after, zero clamp after}
    function automatic [4:0] exp_stop(input [15:0] a, input tm);
        logic d;
        d = a[8] & !tm;
        return {!d & !a[6], !d & a[6], d, !(d & a[9]), d & a[9]};
    endfunction
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        cyc(12);
        rst <= 1'h0;
        cyc(8);
        // reset values and a hole in the map
        rd(`TLDC_OFS_SW_A, 32'h80);
        rd(`TLDC_OFS_SW_B, 32'h0);
        rd(`TLDC_OFS_EMG_TRQ, 32'h0);
        rd(`TLDC_OFS_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        // every pin pattern, honoured and then ignored
        for (k = 0; k < 4; k++) begin
            frc <= k[1:0];
            wr(`TLDC_OFS_SW_A, 32'h0);
            cyc(8);
            `CHK("allowed", {~k[0], ~k[1]}, {fwd_allowed_q, rev_allowed_q})
            wr(`TLDC_OFS_SW_A, 32'hc);
            cyc(8);
            `CHK("ignored", 2'h3, {fwd_allowed_q, rev_allowed_q})
        end
        // overtravel in mid-run under each stop style
        wr(`TLDC_OFS_EMG_TRQ, 32'h123);
        for (k = 0; k < 5; k++) begin
            frc <= 2'h0;
            run_req <= 1'h0;
            torque_mode <= k == 4;
            wr(`TLDC_OFS_SW_A, {16'h0, sw_tab[k]});
            wr(`TLDC_OFS_IRQ_STAT, 32'h7);
            wr(`TLDC_OFS_IRQ_MASK, 32'h5);
            cyc(8);
            run_req <= 1'h1;
            cyc(4);
            `CHK("run_allow", 1'h1, run_allow_q)
            frc <= 2'h1;
            cyc(8);
            e = exp_stop(sw_tab[k], k == 4);
            `CHK("stop", e[4:2], {stop_dyn_brake_q, stop_coast_q, stop_decel_q})
            `CHK("torque", e[2] ? 16'h123 : 16'h0, stop_torque_q)
            for (i = 0; i < 50 && motor_stopped !== 1'h1; i++) cyc(1);
            if (i == 50) begin
                err_count++;
                finish_test();
            end
            cyc(3);
            `CHK("held", e[1:0], {servo_off_q, zero_clamp_q})
            `CHK("irq", 1'h1, irq)
            rd(`TLDC_OFS_IRQ_STAT, 32'h5);
        end
        wr(`TLDC_OFS_IRQ_STAT, 32'h5);
        `CHK("irq clear", 1'h0, irq)
        // limit ignored: no stop at all
        frc <= 2'h0;
        run_req <= 1'h0;
        torque_mode <= 1'h0;
        wr(`TLDC_OFS_SW_A, 32'h104);
        cyc(8);
        run_req <= 1'h1;
        frc <= 2'h1;
        cyc(8);
        `CHK("ignored stop", 2'h2, {run_allow_q, stop_decel_q})
        rd(`TLDC_OFS_STATUS, 32'h44);
        // random traffic with limits honoured
        frc <= 2'h0;
        wr(`TLDC_OFS_SW_A, 32'h0);
        for (k = 0; k < 60; k++) begin
            l = lfsr(l);
            run_req <= l[0];
            run_reverse <= l[1];
            torque_mode <= l[2];
            encoder_connector_strap <= l[3];
            wr(`TLDC_OFS_SW_B, {31'h0, l[4]});
            cyc(6);
            `CHK("cw", l[1] ^ (l[3] | l[4]), motor_cw_q)
            `CHK("axis", l[3] | l[4], axis_invert_q)
        end
        finish_test();
    end
endmodule
